/* File: verilog/ssp_core.sv */
// Synchronous serial port: SPI master/slave and two-wire master sequencing
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_core #(
   parameter int DATA_W = 8,
   parameter int BRG_W  = 7
) (
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              port_enable_bit,
   input  wire logic              i2c_mode,
   input  wire logic              spi_master,
   input  wire logic              spi_clk_idle_high,
   input  wire logic              spi_clk_phase,
   input  wire logic              spi_sample_end,
   input  wire ssp_pkg::ssp_rate_t spi_rate,
   input  wire logic              spi_select_en,
   input  wire logic              timer_tick,
   input  wire logic [BRG_W-1:0]  baud_reload_value,
   input  wire logic              buf_wr_en,
   input  wire logic [DATA_W-1:0] buf_wr_data,
   input  wire logic              seq_wr_en,
   input  wire logic [4:0]        seq_wr_data,
   input  wire logic              write_collision_flag_clr,
   input  wire logic              bcl_clr,
   input  wire logic              irq_clr,
   output wire logic [DATA_W-1:0] rx_data,
   output wire logic              rx_valid,
   input  wire logic              rx_ready,
   input  wire logic              sck_in,
   output wire logic              sck_o,
   output wire logic              sck_oe_n,
   input  wire logic              sdi,
   output wire logic              sdo_o,
   output wire logic              sdo_oe_n,
   input  wire logic              ss_n,
   input  wire logic              sda_in,
   output wire logic              sda_o,
   output wire logic              sda_oe_n,
   input  wire logic              scl_in,
   output wire logic              scl_o,
   output wire logic              scl_oe_n,
   output wire logic [DATA_W-1:0] shift_buffer_reg,
   output wire logic              start_enable_bit,
   output wire logic              stop_enable_bit,
   output wire logic              start_detected,
   output wire logic              stop_detected,
   output wire logic              bus_collision_flag,
   output wire logic              write_collision_flag,
   output wire logic              serial_port_irq_flag
);
   import ssp_pkg::*;

   localparam int HW = $clog2(2 * DATA_W);
   localparam int IW = $clog2(2 * DATA_W + 2);
   localparam logic [HW-1:0] SPI_LAST = HW'(2 * DATA_W - 1);
   localparam logic [IW-1:0] I2C_LAST = IW'(2 * DATA_W + 1);
   localparam logic [IW-1:0] I2C_ACK  = IW'(2 * DATA_W);

   if (DATA_W < 2 || DATA_W > 16 || BRG_W < 1 || BRG_W > 8) begin : g_bad
      $error("ssp_core: DATA_W must be 2..16 and BRG_W 1..8");
   end

   // ==========================================================
   // Declarations
   logic              en;
   logic [DATA_W-1:0] buf_r;
   logic              pend_r;
   logic              seq_start_r;
   logic              seq_stop_r;
   logic              s_det_r;
   logic              p_det_r;
   logic              bcl_r;
   logic              write_collision_flag_r;
   logic              irq_r;
   logic              od_low_r;
   logic              spi_run_r;
   logic              spi_done_r;
   logic              sck_r;
   logic              sck_prev_r;
   logic              sdo_r;
   logic              sck_oe_n_r;
   logic              sdo_oe_n_r;
   logic [HW-1:0]     half_r;
   logic [5:0]        div_cnt_r;
   logic [5:0]        div_last;
   logic [DATA_W-1:0] tx_sh_r;
   logic [DATA_W-1:0] rx_sh_r;
   ssp_i2c_st_t       st_r;
   logic [BRG_W-1:0]  brg_cnt_r;
   logic [IW-1:0]     bit_r;
   logic [DATA_W-1:0] i2c_sh_r;
   logic              sda_oe_n_r;
   logic              scl_oe_n_r;
   logic              i2c_push_r;
   logic [DATA_W-1:0] head_r;
   logic [DATA_W-1:0] tail_r;
   logic              head_v_r;
   logic              tail_v_r;

   assign en = port_enable_bit;

   // ==========================================================
   // Event decode
   logic spi_on;
   logic i2c_on;
   logic slv_sel;
   logic tick;
   logic edge_go;
   logic out_edge;
   logic samp;
   logic spi_ld;
   logic lines_hi;
   logic brg_to;
   logic ev_st_go;
   logic ev_bcl;
   logic ev_s;
   logic ev_st_done;
   logic ev_sp_go;
   logic ev_p;
   logic ev_sp_done;
   logic i2c_byte_go;
   logic ev_byte_done;
   logic write_collision_flag_ev;
   logic buf_ok;
   logic in_ready;
   logic push_v;
   logic [DATA_W-1:0] push_d;
   logic pop;

   always_comb begin
      unique case (spi_rate)
         SSP_RATE_DIV4:  div_last = `SSP_DIV4_LAST;
         SSP_RATE_DIV16: div_last = `SSP_DIV16_LAST;
         SSP_RATE_DIV64: div_last = `SSP_DIV64_LAST;
         SSP_RATE_TIMER: div_last = `SSP_DIV64_LAST;
      endcase
   end

   assign spi_on   = en & ~i2c_mode;
   assign i2c_on   = en & i2c_mode;
   assign slv_sel  = ~spi_select_en | ~ss_n;
   assign tick     = (spi_rate == SSP_RATE_TIMER) ? timer_tick
                                                  : (div_cnt_r == div_last);
   assign edge_go  = spi_run_r & (spi_master ? tick : (sck_in != sck_prev_r));
   assign out_edge = half_r[0] ^ spi_clk_phase;
   assign samp     = spi_sample_end ? ((out_edge && half_r != '0) || half_r == SPI_LAST)
                                    : ~out_edge;
   assign spi_ld   = spi_on & pend_r & ~spi_run_r & in_ready & (spi_master | slv_sel);

   assign lines_hi     = sda_in & scl_in;
   assign brg_to       = (brg_cnt_r == '0);
   assign ev_st_go     = i2c_on & (st_r == SSP_I2C_IDLE) & seq_start_r;
   assign ev_bcl       = (ev_st_go & ~lines_hi)
                       | (i2c_on & (st_r == SSP_I2C_ST_WAIT) & ~lines_hi);
   assign ev_s         = i2c_on & (st_r == SSP_I2C_ST_WAIT) & lines_hi & brg_to;
   assign ev_st_done   = i2c_on & (st_r == SSP_I2C_ST_HOLD) & brg_to;
   assign ev_sp_go     = i2c_on & (st_r == SSP_I2C_IDLE) & ~seq_start_r & seq_stop_r;
   assign ev_p         = i2c_on & (st_r == SSP_I2C_SP_CHK) & lines_hi;
   assign ev_sp_done   = i2c_on & (st_r == SSP_I2C_SP_END) & brg_to;
   assign i2c_byte_go  = i2c_on & (st_r == SSP_I2C_IDLE) & ~seq_start_r & ~seq_stop_r
                       & pend_r & in_ready;
   assign ev_byte_done = i2c_on & (st_r == SSP_I2C_BYTE) & brg_to & (bit_r == I2C_LAST);

   assign write_collision_flag_ev = en & buf_wr_en
                  & (pend_r | (i2c_mode ? (st_r != SSP_I2C_IDLE) : spi_run_r));
   assign buf_ok  = en & buf_wr_en & ~write_collision_flag_ev;

   // ==========================================================
   // Shift buffer register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         buf_r  <= `SSP_BUF_RESET;
         pend_r <= 1'b0;
      end else if (!en) begin
         pend_r <= 1'b0;
      end else if (buf_ok) begin
         buf_r  <= buf_wr_data;
         pend_r <= 1'b1;
      end else if (spi_ld || i2c_byte_go) begin
         pend_r <= 1'b0;
      end
   end

   // ==========================================================
   // SPI shifter
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         spi_run_r  <= 1'b0;
         spi_done_r <= 1'b0;
         sck_r      <= 1'b0;
         sck_prev_r <= 1'b0;
         sdo_r      <= 1'b0;
         half_r     <= '0;
         div_cnt_r  <= '0;
         tx_sh_r    <= '0;
         rx_sh_r    <= '0;
      end else begin
         sck_prev_r <= sck_in;
         spi_done_r <= 1'b0;
         if (!spi_on || (!spi_master && !slv_sel)) begin
            spi_run_r <= 1'b0;
            half_r    <= '0;
            div_cnt_r <= '0;
            sck_r     <= spi_clk_idle_high;
         end else if (spi_ld) begin
            spi_run_r <= 1'b1;
            half_r    <= '0;
            div_cnt_r <= '0;
            sdo_r     <= buf_r[DATA_W-1];
            tx_sh_r   <= spi_clk_phase ? buf_r : {buf_r[DATA_W-2:0], 1'b0};
         end else if (spi_run_r) begin
            div_cnt_r <= tick ? 6'h00 : div_cnt_r + 6'h01;
            if (edge_go) begin
               if (spi_master) begin
                  sck_r <= ~sck_r;
               end
               if (samp) begin
                  rx_sh_r <= {rx_sh_r[DATA_W-2:0], sdi};
               end
               if (out_edge) begin
                  sdo_r   <= tx_sh_r[DATA_W-1];
                  tx_sh_r <= {tx_sh_r[DATA_W-2:0], 1'b0};
               end
               if (half_r == SPI_LAST) begin
                  spi_run_r  <= 1'b0;
                  half_r     <= '0;
                  spi_done_r <= 1'b1;
               end else begin
                  half_r <= half_r + 1'b1;
               end
            end
         end else begin
            sck_r <= spi_clk_idle_high;
         end
      end
   end

   // SPI pin enables
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sck_oe_n_r <= 1'b1;
         sdo_oe_n_r <= 1'b1;
      end else begin
         sck_oe_n_r <= ~(spi_on & spi_master);
         sdo_oe_n_r <= ~(spi_on & (spi_master | slv_sel));
      end
   end

   // ==========================================================
   // Two-wire sequencer with baud rate generator
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r       <= SSP_I2C_IDLE;
         brg_cnt_r  <= '0;
         bit_r      <= '0;
         i2c_sh_r   <= '0;
         sda_oe_n_r <= 1'b1;
         scl_oe_n_r <= 1'b1;
         i2c_push_r <= 1'b0;
      end else if (!i2c_on) begin
         st_r       <= SSP_I2C_IDLE;
         sda_oe_n_r <= 1'b1;
         scl_oe_n_r <= 1'b1;
         i2c_push_r <= 1'b0;
      end else begin
         i2c_push_r <= ev_byte_done;
         brg_cnt_r  <= brg_to ? baud_reload_value : brg_cnt_r - 1'b1;
         unique case (st_r)
            SSP_I2C_IDLE: begin
               if (ev_st_go) begin
                  if (lines_hi) begin
                     brg_cnt_r <= baud_reload_value;
                     st_r      <= SSP_I2C_ST_WAIT;
                  end
               end else if (ev_sp_go) begin
                  sda_oe_n_r <= 1'b0;
                  st_r       <= SSP_I2C_SP_LOW;
               end else if (i2c_byte_go) begin
                  scl_oe_n_r <= 1'b0;
                  sda_oe_n_r <= buf_r[DATA_W-1];
                  i2c_sh_r   <= buf_r;
                  bit_r      <= '0;
                  brg_cnt_r  <= baud_reload_value;
                  st_r       <= SSP_I2C_BYTE;
               end
            end
            SSP_I2C_ST_WAIT: begin
               if (!lines_hi) begin
                  st_r <= SSP_I2C_IDLE;
               end else if (brg_to) begin
                  sda_oe_n_r <= 1'b0;
                  st_r       <= SSP_I2C_ST_HOLD;
               end
            end
            SSP_I2C_ST_HOLD: begin
               if (brg_to) begin
                  st_r <= SSP_I2C_IDLE;
               end
            end
            SSP_I2C_BYTE: begin
               if (brg_to) begin
                  scl_oe_n_r <= ~bit_r[0];
                  bit_r      <= bit_r + 1'b1;
                  if (bit_r == I2C_LAST) begin
                     sda_oe_n_r <= 1'b1;
                     st_r       <= SSP_I2C_IDLE;
                  end else if (bit_r[0]) begin
                     i2c_sh_r <= {i2c_sh_r[DATA_W-2:0], sda_in};
                     if (bit_r + 1'b1 == I2C_ACK) begin
                        sda_oe_n_r <= 1'b1;
                     end else begin
                        sda_oe_n_r <= i2c_sh_r[DATA_W-2];
                     end
                  end
               end
            end
            SSP_I2C_SP_LOW: begin
               if (!sda_in) begin
                  brg_cnt_r <= baud_reload_value;
                  st_r      <= SSP_I2C_SP_SCL;
               end
            end
            SSP_I2C_SP_SCL: begin
               if (brg_to) begin
                  scl_oe_n_r <= 1'b1;
                  st_r       <= SSP_I2C_SP_SDA;
               end
            end
            SSP_I2C_SP_SDA: begin
               if (brg_to) begin
                  sda_oe_n_r <= 1'b1;
                  st_r       <= SSP_I2C_SP_CHK;
               end
            end
            SSP_I2C_SP_CHK: begin
               if (lines_hi) begin
                  brg_cnt_r <= baud_reload_value;
                  st_r      <= SSP_I2C_SP_END;
               end
            end
            SSP_I2C_SP_END: begin
               if (brg_to) begin
                  st_r <= SSP_I2C_IDLE;
               end
            end
            default: st_r <= SSP_I2C_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Sequence control bits
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         seq_start_r <= 1'b0;
         seq_stop_r  <= 1'b0;
      end else if (!en) begin
         seq_start_r <= 1'b0;
         seq_stop_r  <= 1'b0;
      end else begin
         if (seq_wr_en && !seq_start_r) begin
            seq_start_r <= seq_wr_data[`SSP_SEQ_START_POS];
            seq_stop_r  <= seq_wr_data[`SSP_SEQ_STOP_POS];
         end
         if (ev_st_done || ev_bcl) begin
            seq_start_r <= 1'b0;
         end
         if (ev_sp_done) begin
            seq_stop_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Status flags; a set in the same cycle as a clear wins
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_det_r  <= 1'b0;
         p_det_r  <= 1'b0;
         bcl_r    <= 1'b0;
         write_collision_flag_r   <= 1'b0;
         irq_r    <= 1'b0;
         od_low_r <= 1'b0;
      end else begin
         od_low_r <= 1'b0;
         if (!en) begin
            s_det_r <= 1'b0;
            p_det_r <= 1'b0;
         end else if (ev_s) begin
            s_det_r <= 1'b1;
            p_det_r <= 1'b0;
         end else if (ev_p) begin
            p_det_r <= 1'b1;
            s_det_r <= 1'b0;
         end
         bcl_r  <= ev_bcl | (bcl_r & ~bcl_clr);
         write_collision_flag_r <= write_collision_flag_ev | (write_collision_flag_r & ~write_collision_flag_clr);
         irq_r  <= ev_sp_done | ev_byte_done | spi_done_r
                 | (irq_r & ~irq_clr);
      end
   end

   // ==========================================================
   // Two-entry receive buffer
   assign in_ready = ~tail_v_r;
   assign push_v   = spi_done_r | i2c_push_r;
   assign push_d   = i2c_mode ? i2c_sh_r : rx_sh_r;
   assign pop      = head_v_r & rx_ready;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         head_r   <= '0;
         tail_r   <= '0;
         head_v_r <= 1'b0;
         tail_v_r <= 1'b0;
      end else if (pop) begin
         head_v_r <= tail_v_r | push_v;
         head_r   <= tail_v_r ? tail_r : push_d;
         tail_v_r <= 1'b0;
      end else if (push_v && !head_v_r) begin
         head_v_r <= 1'b1;
         head_r   <= push_d;
      end else if (push_v && !tail_v_r) begin
         tail_v_r <= 1'b1;
         tail_r   <= push_d;
      end
   end

   // ==========================================================
   // Outputs
   assign rx_data              = head_r;
   assign rx_valid             = head_v_r;
   assign sck_o                = sck_r;
   assign sck_oe_n             = sck_oe_n_r;
   assign sdo_o                = sdo_r;
   assign sdo_oe_n             = sdo_oe_n_r;
   assign sda_o                = od_low_r;
   assign sda_oe_n             = sda_oe_n_r;
   assign scl_o                = od_low_r;
   assign scl_oe_n             = scl_oe_n_r;
   assign shift_buffer_reg     = buf_r;
   assign start_enable_bit     = seq_start_r;
   assign stop_enable_bit      = seq_stop_r;
   assign start_detected       = s_det_r;
   assign stop_detected        = p_det_r;
   assign bus_collision_flag   = bcl_r;
   assign write_collision_flag = write_collision_flag_r;
   assign serial_port_irq_flag = irq_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   chk_spi_word_end: assert property (spi_on && edge_go && half_r == SPI_LAST && !spi_ld
      |=> spi_done_r && !spi_run_r ##1 head_v_r) else $error("spi word not delivered");
   chk_sck_idle_lvl: assert property (spi_on && !spi_run_r && !spi_ld && $past(spi_on)
      |=> sck_r == $past(spi_clk_idle_high)) else $error("sck not at idle level");
   chk_master_drive: assert property (##1 sck_oe_n_r == !$past(spi_on && spi_master))
      else $error("sck enable wrong");
   chk_disable_free: assert property (!en |=> sda_oe_n_r && scl_oe_n_r && sck_oe_n_r
      && st_r == SSP_I2C_IDLE && !spi_run_r) else $error("pins held while disabled");
   chk_timer_only: assert property (spi_on && spi_run_r && spi_master && !spi_ld
      && spi_rate == SSP_RATE_TIMER && !timer_tick |=> sck_r == $past(sck_r))
      else $error("sck moved without timer");
   chk_start_load: assert property (ev_st_go && lines_hi
      |=> st_r == SSP_I2C_ST_WAIT && brg_cnt_r == $past(baud_reload_value))
      else $error("start did not load generator");
   chk_start_cond: assert property (ev_s |=> !sda_oe_n_r && scl_oe_n_r && s_det_r
      && !p_det_r) else $error("start condition wrong");
   chk_start_done: assert property (ev_st_done && !seq_wr_en
      |=> !seq_start_r && !sda_oe_n_r && st_r == SSP_I2C_IDLE)
      else $error("start not completed");
   chk_bus_coll: assert property (ev_bcl |=> bcl_r && !seq_start_r
      && st_r == SSP_I2C_IDLE) else $error("collision not handled");
   chk_write_collision_flag_keep: assert property (write_collision_flag_ev |=> write_collision_flag_r && buf_r == $past(buf_r))
      else $error("refused write changed buffer");
   chk_seq_lock: assert property (seq_start_r && en && !ev_st_done && !ev_bcl
      |=> seq_start_r && seq_stop_r == $past(seq_stop_r)) else $error("sequence bits moved");
   chk_scl_hold: assert property (ev_byte_done |=> !scl_oe_n_r ##1 !scl_oe_n_r || !en)
      else $error("scl not held low");
   chk_stop_scl: assert property (i2c_on && st_r == SSP_I2C_SP_SCL && brg_to
      |=> scl_oe_n_r && !sda_oe_n_r && st_r == SSP_I2C_SP_SDA)
      else $error("stop scl release wrong");
   chk_stop_seen: assert property (ev_p |=> p_det_r && !s_det_r
      && st_r == SSP_I2C_SP_END) else $error("stop detect wrong");
   chk_stop_end: assert property (ev_sp_done |=> !seq_stop_r && irq_r)
      else $error("stop end wrong");

   cov_spi_word:  cover property (spi_done_r ##1 head_v_r);
   cov_start_ok:  cover property (ev_s ##[1:300] ev_st_done);
   cov_stop_ok:   cover property (ev_sp_go ##[1:600] ev_sp_done);
   cov_full_buf:  cover property (tail_v_r && !rx_ready);
endmodule : ssp_core

/* File: verilog/ssp_defines.svh */
// Constants for the synchronous serial port
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// Last count of each half clock period of the SPI master
`define SSP_DIV4_LAST  6'h01
`define SSP_DIV16_LAST 6'h07
`define SSP_DIV64_LAST 6'h1F

// Positions inside the sequence control write
`define SSP_SEQ_START_POS 0
`define SSP_SEQ_STOP_POS  2
`define SSP_SEQ_WIDTH     5

// Reset values
`define SSP_BUF_RESET 8'h00

`endif

/* File: verilog/ssp_pkg.sv */
// Types shared by the synchronous serial port
package ssp_pkg;
   typedef enum logic [1:0] {
      SSP_RATE_DIV4,
      SSP_RATE_DIV16,
      SSP_RATE_DIV64,
      SSP_RATE_TIMER
   } ssp_rate_t;

   typedef enum logic [3:0] {
      SSP_I2C_IDLE,
      SSP_I2C_ST_WAIT,
      SSP_I2C_ST_HOLD,
      SSP_I2C_BYTE,
      SSP_I2C_SP_LOW,
      SSP_I2C_SP_SCL,
      SSP_I2C_SP_SDA,
      SSP_I2C_SP_CHK,
      SSP_I2C_SP_END
   } ssp_i2c_st_t;
endpackage : ssp_pkg

/* File: testbench/ssp_peer.sv */
// Far-side model: SPI loopback peer and pulled-up two-wire bus lines
`timescale 1ns/1ps
module ssp_peer (
   input  wire logic sdo_o,
   input  wire logic sdo_oe_n,
   input  wire logic sda_oe_n,
   input  wire logic scl_oe_n,
   input  wire logic hold_scl,
   output wire logic sdi,
   output wire logic sda_in,
   output wire logic scl_in
);
   // Undriven data line shows the inverse so a stale value never passes
   assign sdi    = sdo_oe_n ? ~sdo_o : sdo_o;
   // Pull-ups; the peer may stretch SCL low
   assign sda_in = sda_oe_n;
   assign scl_in = scl_oe_n & ~hold_scl;
endmodule : ssp_peer

/* File: testbench/tb.sv */
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module tb;
   import ssp_pkg::*;
   logic       core_clk = 0, sys_rst = 1, port_enable_bit = 0, i2c_mode = 0, spi_master = 1;
   logic       spi_clk_idle_high = 0, spi_clk_phase = 0, spi_sample_end = 0, spi_select_en = 0;
   logic       timer_tick = 0, buf_wr_en = 0, seq_wr_en = 0, write_collision_flag_clr = 0, bcl_clr = 0;
   logic       irq_clr = 0, rx_ready = 0, sck_in = 0, ss_n = 1, hold_scl = 0;
   ssp_rate_t  spi_rate = SSP_RATE_DIV4;
   logic [6:0] baud_reload_value = 7'h02;
   logic [7:0] buf_wr_data = 8'h00;
   logic [4:0] seq_wr_data = 5'h00;
   wire logic [7:0] rx_data, shift_buffer_reg;
   wire logic  rx_valid, sck_o, sck_oe_n, sdi, sdo_o, sdo_oe_n, sda_in, sda_o, sda_oe_n;
   wire logic  scl_in, scl_o, scl_oe_n, start_enable_bit, stop_enable_bit, start_detected;
   wire logic  stop_detected, bus_collision_flag, write_collision_flag, serial_port_irq_flag;
   wire logic [5:0] ev = {!stop_enable_bit, bus_collision_flag, stop_detected,
                          !start_enable_bit, start_detected, rx_valid};
   int         fail_count = 0, samples_checked = 0, i, n;
   // Rows: {idle high, phase, sample at end, rate code, data}
   logic [12:0] rows [4] = '{13'h00A5, 13'h113C, 13'h08C3, 13'h1F7E};
   ssp_core i_ssp_core (.core_clk, .sys_rst, .port_enable_bit, .i2c_mode, .spi_master,
      .spi_clk_idle_high, .spi_clk_phase, .spi_sample_end, .spi_rate, .spi_select_en,
      .timer_tick, .baud_reload_value, .buf_wr_en, .buf_wr_data, .seq_wr_en, .seq_wr_data,
      .write_collision_flag_clr, .bcl_clr, .irq_clr, .rx_data, .rx_valid, .rx_ready, .sck_in, .sck_o,
      .sck_oe_n, .sdi, .sdo_o, .sdo_oe_n, .ss_n, .sda_in, .sda_o, .sda_oe_n, .scl_in, .scl_o,
      .scl_oe_n, .shift_buffer_reg, .start_enable_bit, .stop_enable_bit, .start_detected,
      .stop_detected, .bus_collision_flag, .write_collision_flag, .serial_port_irq_flag);
   ssp_peer i_ssp_peer (.sdo_o, .sdo_oe_n, .sda_oe_n, .scl_oe_n, .hold_scl, .sdi, .sda_in,
      .scl_in);
   initial forever #20 core_clk = ~core_clk;
   // Timer output: one tick every second cycle
   always @(negedge core_clk) timer_tick = ~timer_tick;
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task give_verdict;
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   task wt(input int k);
      for (n = 0; n < 3000 && ev[k] !== 1'b1; n++) @(negedge core_clk);
      if (n == 3000) begin
         fail_count++;
         give_verdict;
      end
   endtask : wt
   task pulse(input int k, input logic [7:0] d);
      if (k == 0) {buf_wr_en, buf_wr_data} = {1'b1, d};
      else {seq_wr_en, seq_wr_data} = {1'b1, d[4:0]};
      @(negedge core_clk);
      {buf_wr_en, seq_wr_en} = 2'b00;
      @(negedge core_clk);
   endtask : pulse
   task reenable;
      port_enable_bit = 0;
      @(negedge core_clk);
      port_enable_bit = 1;
      repeat (2) @(negedge core_clk);
   endtask : reenable
   initial begin
      repeat (4) @(negedge core_clk);
      sys_rst = 0;
      chk({sda_oe_n, scl_oe_n, sck_oe_n, sdo_oe_n, rx_valid, write_collision_flag,
           bus_collision_flag, serial_port_irq_flag}, 8'hF0);
      $display("reset test done");
      for (i = 0; i < 4; i++) begin
         {spi_clk_idle_high, spi_clk_phase, spi_sample_end} = rows[i][12:10];
         spi_rate = ssp_rate_t'(rows[i][9:8]);
         reenable;
         chk({6'h00, sck_oe_n, sck_o}, {7'h00, spi_clk_idle_high});
         pulse(0, rows[i][7:0]);
         wt(0);
         chk(rx_data, rows[i][7:0]);
         rx_ready = 1;
         @(negedge core_clk);
         rx_ready = 0;
         $display("spi row %0d done", i);
      end
      // Slave: the bench clocks sck_in, the peer loops data back
      spi_master = 0;
      spi_select_en = 1;
      ss_n = 0;
      reenable;
      pulse(0, 8'h96);
      for (i = 0; i < 16; i++) begin
         sck_in = ~sck_in;
         repeat (2) @(negedge core_clk);
      end
      wt(0);
      chk(rx_data, 8'h96);
      chk({6'h00, sck_oe_n, sdo_oe_n}, 8'h02);
      rx_ready = 1;
      @(negedge core_clk);
      rx_ready = 0;
      $display("slave test done");
      i2c_mode = 1;
      reenable;
      pulse(1, 8'h01);
      pulse(1, 8'h04);
      pulse(0, 8'h77);
      chk({stop_enable_bit, write_collision_flag}, 8'h01);
      chk(shift_buffer_reg, 8'h96);
      wt(1);
      chk({sda_o, scl_o, sda_oe_n, scl_oe_n, start_enable_bit}, 8'h03);
      wt(2);
      chk({start_detected, sda_oe_n, scl_oe_n}, 8'h05);
      {write_collision_flag_clr, irq_clr} = 2'b11;
      @(negedge core_clk);
      {write_collision_flag_clr, irq_clr} = 2'b00;
      $display("start test done");
      // One byte out; open-drain loopback returns it
      pulse(0, 8'hA6);
      wt(0);
      chk(rx_data, 8'hA6);
      chk({6'h00, scl_oe_n, serial_port_irq_flag}, 8'h01);
      {rx_ready, irq_clr} = 2'b11;
      @(negedge core_clk);
      {rx_ready, irq_clr} = 2'b00;
      $display("byte test done");
      pulse(1, 8'h04);
      repeat (2) @(negedge core_clk);
      pulse(0, 8'h55);
      chk({sda_oe_n, write_collision_flag}, 8'h01);
      chk(shift_buffer_reg, 8'hA6);
      wt(3);
      chk({start_detected, sda_oe_n, scl_oe_n}, 8'h03);
      wt(5);
      chk({serial_port_irq_flag, stop_detected}, 8'h03);
      $display("stop test done");
      chk({7'h00, stop_detected}, 8'h01);
      hold_scl = 1;
      pulse(1, 8'h01);
      wt(4);
      repeat (2) @(negedge core_clk);
      chk({start_enable_bit, sda_oe_n, start_detected}, 8'h02);
      bcl_clr = 1;
      hold_scl = 0;
      @(negedge core_clk);
      bcl_clr = 0;
      @(negedge core_clk);
      chk({7'h00, bus_collision_flag}, 8'h00);
      $display("collision test done");
      sys_rst = 1;
      @(negedge core_clk);
      chk({sda_oe_n, scl_oe_n, stop_detected, serial_port_irq_flag, start_detected,
           write_collision_flag, bus_collision_flag, rx_valid}, 8'hC0);
      sys_rst = 0;
      @(negedge core_clk);
      chk(shift_buffer_reg, 8'h00);
      $display("mid-run reset test done");
      give_verdict;
   end
endmodule : tb
